// [hdl/ffskm_consts.svh]
`ifndef FFSKM_CONSTS_SVH
`define FFSKM_CONSTS_SVH
// Register offsets on the plain register port
`define FFSKM_A_MODE      8'hc1
`define FFSKM_A_AMODE     8'hc2
`define FFSKM_A_ACTRL     8'hc3
`define FFSKM_A_AUX       8'hcc
`define FFSKM_A_IRQ       8'hc6
`define FFSKM_A_TXCTL     8'hb5
`define FFSKM_A_TXD1      8'hb6
`define FFSKM_A_RXD1      8'hb8
`define FFSKM_A_RXD3      8'hba
`define FFSKM_A_RXD4      8'hbb
`define FFSKM_A_SYNC_C    8'hd0
`define FFSKM_A_SYNC_D    8'hd1
`define FFSKM_A_SYNC_X    8'hd2
`define FFSKM_A_PREAMBLE  8'hd3
// Field positions
`define FFSKM_B_ENABLE    8
`define FFSKM_B_TXRATE    0
`define FFSKM_B_DETECTED_RATE_FLAG    1
`define FFSKM_B_INBAND    3
`define FFSKM_B_WRDY      4
`define FFSKM_B_TRANSMIT_COMPLETE_EVENT    5
`define FFSKM_B_AUXRATE   8
// Reset values and codes
`define FFSKM_SYNC_RESET  16'hcb23
`define FFSKM_TX_END      16'h0030
`define FFSKM_PRE_RESET   16'haaaa
// Timing: system clock and tone phase step (2^-24 cycle units of a 24 bit accumulator)
`define FFSKM_CLK_HZ      10000000
`define FFSKM_BAUD_LO     1200
`define FFSKM_BAUD_HI     2400
`define FFSKM_BIT_LO      (`FFSKM_CLK_HZ / `FFSKM_BAUD_LO)
`define FFSKM_BIT_HI      (`FFSKM_CLK_HZ / `FFSKM_BAUD_HI)
`define FFSKM_NCO_1200    ((1200 * 65536) / `FFSKM_CLK_HZ * 256 + 2013)
`endif

// [hdl/ffskm_pkg.sv]
package ffskm_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_SYNC, TX_DATA} ffskm_txst_t;
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } ffskm_bus_t;
endpackage : ffskm_pkg

// [hdl/ffskm_modem.sv]
// Operation
// - Modem runs only while the mode control enable bit is set.
// - Tx tones: 1200 baud 1=1c 1200Hz, 0=1.5c 1800Hz; 2400 baud 1=0.5c 1200Hz, 0=1c 2400Hz.
// - Transmission is preamble, then 16-bit sync, then data words.
// - Receive rate comes from the receive part of the format field.
// - Receive bit clock recovered by a PLL; never driven out.
// - Each decoded word goes to a two-byte buffer with word-ready; overwritten.
// - Incoming bits compared to programmable sync, reset CB23, in-band event.
// - Sync search stops after match; re-enable restarts it.
// - Four sync words; inverted one is always inverse of control sync.
// - Each sync detect posts a code and a rate flag in aux status.
// - After sync each data word lands in receive word register 1.
// - Preceding words reported in receive registers 3 and 4; host validates.
// - Receiver keeps decoding until host disables it; here it also takes no bit samples while tx is not idle.
// - Tx sends preamble then the sync word chosen by sync-select.
// - Tx rate follows tx format; latched only at enable.
// - Tx amplitude set by the tone transmit level field.
// - Device flags word-ready per word needed; host writes next word.
// - Internal bit clock shifts transmit word 1 out MSB first.
// - Writing 0030 to transmit control ends tx; done after last bit.
// - Modem runs alongside other signalling; no interlock with them.
// - In-band events set bit 3 of the interrupt status register.
`timescale 1ns/1ps
`default_nettype none
`include "ffskm_consts.svh"
module ffskm_modem (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rstn,
    // Register port
    input  wire ffskm_pkg::ffskm_bus_t i_bus,
    output logic [15:0]               o_rdata,
    // Demodulated hard-limited receive data (asynchronous)
    input  wire logic                 i_rx_bit,
    // Modulator output: unsigned sample scaled by tone level
    output logic [11:0]               o_tx_sample,
    output logic                      o_tx_active,
    // Event flags for the host
    output logic                      o_inband_irq,
    output logic                      o_word_ready_event,
    output logic                      o_transmit_complete_event
);
    import ffskm_pkg::*;

    // Registers
    logic [15:0] mode_control_reg_q, analogue_mode_reg_q, analogue_control_reg_q;
    logic [15:0] aux_status_reg_q, interrupt_status_reg_q;
    logic [15:0] transmit_control_word_reg_q, tx_word_q;
    logic [15:0] receive_word_reg_1_q, receive_word_reg_3_q, receive_word_reg_4_q;
    logic [15:0] control_sync_q, data_sync_word_q, extra_sync_word_q, preamble_q;
    logic        tx_word_full_q;
    wire  [15:0] inverted_control_sync_word = ~control_sync_q;
    wire         enable = mode_control_reg_q[`FFSKM_B_ENABLE];
    wire         rd = i_bus.rd;
    wire         wr = i_bus.wr;

    // Events raised by datapath this cycle
    logic ev_sync, ev_rx_word, ev_tx_need, ev_tx_done;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mode_control_reg_q     <= 16'h0000;
            analogue_mode_reg_q    <= 16'h0000;
            analogue_control_reg_q <= 16'h0000;
            control_sync_q         <= `FFSKM_SYNC_RESET;
            data_sync_word_q       <= `FFSKM_SYNC_RESET;
            extra_sync_word_q      <= `FFSKM_SYNC_RESET;
            preamble_q             <= `FFSKM_PRE_RESET;
        end else if (wr) begin
            case (i_bus.addr)
                `FFSKM_A_MODE:     mode_control_reg_q     <= i_bus.wdata;
                `FFSKM_A_AMODE:    analogue_mode_reg_q    <= i_bus.wdata;
                `FFSKM_A_ACTRL:    analogue_control_reg_q <= i_bus.wdata;
                `FFSKM_A_SYNC_C:   control_sync_q         <= i_bus.wdata;
                `FFSKM_A_SYNC_D:   data_sync_word_q       <= i_bus.wdata;
                `FFSKM_A_SYNC_X:   extra_sync_word_q      <= i_bus.wdata;
                `FFSKM_A_PREAMBLE: preamble_q             <= i_bus.wdata;
                default: ;
            endcase
        end
    end

    // Interrupt status: set wins over clear-on-read
    wire irq_rd = rd && (i_bus.addr == `FFSKM_A_IRQ);
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            interrupt_status_reg_q <= 16'h0000;
        end else begin
            interrupt_status_reg_q <= irq_rd ? 16'h0000 : interrupt_status_reg_q;
            if (ev_sync)
                interrupt_status_reg_q[`FFSKM_B_INBAND] <= 1'b1;
            if (ev_rx_word || ev_tx_need)
                interrupt_status_reg_q[`FFSKM_B_WRDY] <= 1'b1;
            if (ev_tx_done)
                interrupt_status_reg_q[`FFSKM_B_TRANSMIT_COMPLETE_EVENT] <= 1'b1;
        end
    end

    inband_status_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_inband_irq |-> interrupt_status_reg_q[`FFSKM_B_INBAND])
        else $error("in-band event without its status bit");

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_rdata <= 16'h0000;
        end else if (rd) begin
            case (i_bus.addr)
                `FFSKM_A_MODE:     o_rdata <= mode_control_reg_q;
                `FFSKM_A_AMODE:    o_rdata <= analogue_mode_reg_q;
                `FFSKM_A_ACTRL:    o_rdata <= analogue_control_reg_q;
                `FFSKM_A_AUX:      o_rdata <= aux_status_reg_q;
                `FFSKM_A_IRQ:      o_rdata <= interrupt_status_reg_q;
                `FFSKM_A_RXD1:     o_rdata <= receive_word_reg_1_q;
                `FFSKM_A_RXD3:     o_rdata <= receive_word_reg_3_q;
                `FFSKM_A_RXD4:     o_rdata <= receive_word_reg_4_q;
                `FFSKM_A_SYNC_C:   o_rdata <= control_sync_q;
                `FFSKM_A_SYNC_D:   o_rdata <= data_sync_word_q;
                `FFSKM_A_SYNC_X:   o_rdata <= extra_sync_word_q;
                `FFSKM_A_PREAMBLE: o_rdata <= preamble_q;
                default:           o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_inband_irq              <= 1'b0;
            o_word_ready_event        <= 1'b0;
            o_transmit_complete_event <= 1'b0;
        end else begin
            o_inband_irq              <= ev_sync;
            o_word_ready_event        <= ev_rx_word || ev_tx_need;
            o_transmit_complete_event <= ev_tx_done;
        end
    end

    // ---------------- Transmit ----------------
    ffskm_txst_t tx_st_q;
    logic        tx_rate_q;       // 1 = 2400 baud, latched at enable
    logic        en_q;
    logic [13:0] tx_bit_cnt_q;
    logic [3:0]  tx_idx_q;
    logic [15:0] tx_shift_q;
    logic        tx_end_q;
    logic [23:0] nco_q;
    wire         en_rise = enable && !en_q;
    wire [13:0]  bit_len = tx_rate_q ? 14'(`FFSKM_BIT_HI) : 14'(`FFSKM_BIT_LO);
    wire         tx_tick = (tx_bit_cnt_q == 14'd0);
    wire         txd_wr  = wr && (i_bus.addr == `FFSKM_A_TXD1);
    wire         txc_wr  = wr && (i_bus.addr == `FFSKM_A_TXCTL);

    // Sync-select code in bits 11:8 of the analogue mode register
    logic [15:0] tx_sync_word;
    always_comb begin
        case (analogue_mode_reg_q[11:8])
            4'h1:    tx_sync_word = data_sync_word_q;
            4'h2:    tx_sync_word = inverted_control_sync_word;
            4'h3:    tx_sync_word = extra_sync_word_q;
            default: tx_sync_word = control_sync_q;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            en_q <= 1'b0;
        end else begin
            en_q <= enable;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            tx_word_q                   <= 16'h0000;
            tx_word_full_q              <= 1'b0;
            transmit_control_word_reg_q <= 16'h0000;
        end else begin
            if (txd_wr) begin
                tx_word_q      <= i_bus.wdata;
                tx_word_full_q <= 1'b1;
            end else if (tx_st_q != TX_IDLE && tx_tick && tx_idx_q == 4'hf
                         && tx_st_q != TX_PRE) begin
                tx_word_full_q <= 1'b0;
            end
            if (txc_wr)
                transmit_control_word_reg_q <= i_bus.wdata;
            else if (en_rise)
                transmit_control_word_reg_q <= 16'h0000;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            tx_st_q      <= TX_IDLE;
            tx_rate_q    <= 1'b0;
            tx_bit_cnt_q <= 14'd0;
            tx_idx_q     <= 4'h0;
            tx_shift_q   <= 16'h0000;
            tx_end_q     <= 1'b0;
            ev_tx_need   <= 1'b0;
            ev_tx_done   <= 1'b0;
        end else begin
            ev_tx_need <= 1'b0;
            ev_tx_done <= 1'b0;
            if (!enable) begin
                tx_st_q <= TX_IDLE;
            end else if (en_rise && tx_word_full_q) begin
                // A loaded first word marks a transmit session; a bare enable only receives
                tx_rate_q    <= analogue_control_reg_q[`FFSKM_B_TXRATE];
                tx_st_q      <= TX_PRE;
                tx_shift_q   <= preamble_q;
                tx_idx_q     <= 4'h0;
                // Full period for the first bit too, at the rate being latched
                tx_bit_cnt_q <= (analogue_control_reg_q[`FFSKM_B_TXRATE] ? 14'(`FFSKM_BIT_HI)
                                 : 14'(`FFSKM_BIT_LO)) - 14'd1;
                tx_end_q     <= 1'b0;
            end else if (tx_st_q != TX_IDLE) begin
                tx_bit_cnt_q <= tx_tick ? bit_len - 14'd1 : tx_bit_cnt_q - 14'd1;
                if (tx_tick) begin
                    tx_shift_q <= {tx_shift_q[14:0], 1'b0};
                    tx_idx_q   <= tx_idx_q + 4'h1;
                    if (tx_idx_q == 4'hf) begin
                        case (tx_st_q)
                            TX_PRE: begin
                                tx_st_q    <= TX_SYNC;
                                tx_shift_q <= tx_sync_word;
                            end
                            TX_SYNC, TX_DATA: begin
                                if (tx_end_q || transmit_control_word_reg_q == `FFSKM_TX_END) begin
                                    tx_st_q    <= TX_IDLE;
                                    ev_tx_done <= 1'b1;
                                end else begin
                                    tx_st_q    <= TX_DATA;
                                    tx_shift_q <= tx_word_q;
                                    ev_tx_need <= 1'b1;
                                end
                            end
                            default: tx_st_q <= TX_IDLE;
                        endcase
                    end
                end
                if (txc_wr && i_bus.wdata == `FFSKM_TX_END)
                    tx_end_q <= 1'b1;
            end
        end
    end

    // Phase-continuous tone: step 1200 Hz for 1, 1800/2400 Hz for 0
    wire        tx_bit = tx_shift_q[15];
    logic [23:0] nco_step;
    always_comb begin
        if (tx_bit)
            nco_step = 24'd2013;
        else if (tx_rate_q)
            nco_step = 24'd4027;
        else
            nco_step = 24'd3020;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            nco_q       <= 24'h000000;
            o_tx_sample <= 12'h000;
            o_tx_active <= 1'b0;
        end else begin
            o_tx_active <= (tx_st_q != TX_IDLE);
            if (tx_st_q == TX_IDLE) begin
                nco_q       <= 24'h000000;
                o_tx_sample <= 12'h000;
            end else begin
                nco_q <= nco_q + nco_step;
                // Triangle shaped tone scaled by tone level field
                o_tx_sample <= {5'h00, nco_q[23] ? ~nco_q[22:16] : nco_q[22:16]}
                               * {8'h00, analogue_control_reg_q[15:12]};
            end
        end
    end

    tx_off_idle_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !enable |-> ##2 !o_tx_active)
        else $error("transmitter active while modem disabled");

    tx_pre_start_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        en_rise && tx_word_full_q |=> tx_st_q == TX_PRE)
        else $error("transmission did not open with the preamble");

    tx_rate_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !en_rise |=> $stable(tx_rate_q))
        else $error("transmit rate changed outside enable");

    level_mute_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        analogue_control_reg_q[15:12] == 4'h0 |=> o_tx_sample == 12'h000)
        else $error("tone sample not muted at zero level");

    // ---------------- Receive ----------------
    logic [2:0]  rx_sync_q;
    logic        rx_lvl_q, rx_prev_q;
    logic        rx_rate;
    logic [13:0] pll_q;
    logic [15:0] rx_shift_q;
    logic        hunting_q;
    logic [3:0]  rx_cnt_q;
    wire  [13:0] rx_len = rx_rate ? 14'(`FFSKM_BIT_HI) : 14'(`FFSKM_BIT_LO);
    assign rx_rate = analogue_control_reg_q[`FFSKM_B_DETECTED_RATE_FLAG];

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rx_sync_q <= 3'b000;
            rx_lvl_q  <= 1'b0;
            rx_prev_q <= 1'b0;
        end else begin
            rx_sync_q <= {rx_sync_q[1:0], i_rx_bit};
            if (rx_sync_q[2] == rx_sync_q[1])
                rx_lvl_q <= rx_sync_q[1];
            rx_prev_q <= rx_lvl_q;
        end
    end

    // Transition nudges the phase toward mid-bit; bit clock stays internal
    wire edge_seen = rx_lvl_q ^ rx_prev_q;
    wire sample    = (pll_q == (rx_len >> 1));
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pll_q <= 14'd0;
        end else if (!enable) begin
            pll_q <= 14'd0;
        end else if (edge_seen) begin
            pll_q <= (pll_q > (rx_len >> 1)) ? pll_q : 14'd0;
        end else begin
            pll_q <= (pll_q >= rx_len - 14'd1) ? 14'd0 : pll_q + 14'd1;
        end
    end

    wire [15:0] next_shift = {rx_shift_q[14:0], rx_lvl_q};
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rx_shift_q           <= 16'h0000;
            hunting_q            <= 1'b1;
            rx_cnt_q             <= 4'h0;
            receive_word_reg_1_q <= 16'h0000;
            receive_word_reg_3_q <= 16'h0000;
            receive_word_reg_4_q <= 16'h0000;
            aux_status_reg_q     <= 16'h0000;
            ev_sync              <= 1'b0;
            ev_rx_word           <= 1'b0;
        end else begin
            ev_sync    <= 1'b0;
            ev_rx_word <= 1'b0;
            if (!enable) begin
                hunting_q <= 1'b1;
                rx_cnt_q  <= 4'h0;
            end else if (sample && tx_st_q == TX_IDLE) begin
                rx_shift_q <= next_shift;
                if (hunting_q) begin
                    if (next_shift == control_sync_q || next_shift == data_sync_word_q
                        || next_shift == inverted_control_sync_word
                        || next_shift == extra_sync_word_q) begin
                        hunting_q <= 1'b0;
                        ev_sync   <= 1'b1;
                        rx_cnt_q  <= 4'h0;
                        receive_word_reg_4_q <= receive_word_reg_3_q;
                        receive_word_reg_3_q <= rx_shift_q;
                        aux_status_reg_q <= {7'h00, rx_rate, 6'h00,
                            (next_shift == control_sync_q) ? 2'd0 :
                            (next_shift == data_sync_word_q) ? 2'd1 :
                            (next_shift == inverted_control_sync_word) ? 2'd2 : 2'd3};
                    end
                end else begin
                    rx_cnt_q <= rx_cnt_q + 4'h1;
                    if (rx_cnt_q == 4'hf) begin
                        receive_word_reg_1_q <= next_shift;
                        ev_rx_word           <= 1'b1;
                    end
                end
            end
        end
    end

    hunt_stop_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !hunting_q |=> !ev_sync)
        else $error("sync reported after the search had stopped");

    aux_rate_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        ev_sync |-> aux_status_reg_q[`FFSKM_B_AUXRATE] == $past(rx_rate))
        else $error("aux status rate flag wrong at sync");

    rx_word_load_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        ev_rx_word |-> receive_word_reg_1_q == $past(next_shift))
        else $error("received word not loaded from the shift register");
endmodule : ffskm_modem
`default_nettype wire

// [test/ffskm_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ffskm_consts.svh"
module ffskm_host_model (
    // Clock
    input  wire logic             i_clk,
    // Register port towards the modem
    output var ffskm_pkg::ffskm_bus_t o_bus,
    input  wire logic [15:0]      i_rdata
);
    import ffskm_pkg::*;

    initial o_bus = '0;

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        o_bus.wr <= 1'b0;
    endtask : reg_wr

    // Read data only stands in the cycle after the strobe, so sample it there
    task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_clk);
        o_bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        o_bus.rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask : reg_rd

    // Rate goes in before the enable bit; a disable first re-arms the search
    task automatic modem_on(input logic [15:0] actrl);
        reg_wr(`FFSKM_A_MODE, 16'h0000);
        reg_wr(`FFSKM_A_ACTRL, actrl);
        reg_wr(`FFSKM_A_MODE, 16'h0100);
    endtask : modem_on

    task automatic modem_off();
        reg_wr(`FFSKM_A_MODE, 16'h0000);
    endtask : modem_off

    task automatic get_word(output logic [15:0] d);
        reg_rd(`FFSKM_A_RXD1, d);
    endtask : get_word

    task automatic put_word(input logic [15:0] d);
        reg_wr(`FFSKM_A_TXD1, d);
    endtask : put_word

    task automatic end_tx();
        reg_wr(`FFSKM_A_TXCTL, `FFSKM_TX_END);
    endtask : end_tx
endmodule : ffskm_host_model
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ffskm_consts.svh"
module testbench;
    import ffskm_pkg::*;

    logic        i_clk;
    logic        i_rstn;
    logic        i_rx_bit;
    ffskm_bus_t  bus;
    wire  logic [15:0] rdata;
    wire  logic [11:0] tx_sample;
    wire  logic        tx_active;
    wire  logic        inband;
    wire  logic        wrdy;
    wire  logic        transmit_complete_event;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          inband_cnt = 0;
    logic [15:0] lfsr = 16'hc0d0;
    logic [15:0] rd;
    logic [15:0] sync_q[$];
    logic        bits_q[$];

    ffskm_modem i_ffskm_modem (
        .i_clk                     (i_clk),
        .i_rstn                    (i_rstn),
        .i_bus                     (bus),
        .o_rdata                   (rdata),
        .i_rx_bit                  (i_rx_bit),
        .o_tx_sample               (tx_sample),
        .o_tx_active               (tx_active),
        .o_inband_irq              (inband),
        .o_word_ready_event        (wrdy),
        .o_transmit_complete_event (transmit_complete_event)
    );

    ffskm_host_model i_ffskm_host_model (
        .i_clk   (i_clk),
        .o_bus   (bus),
        .i_rdata (rdata)
    );

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        if (inband === 1'b1) inband_cnt <= inband_cnt + 1;
    end

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : rnd

    // Model: index of the matching sync slot, ctrl/data/inverted
    function automatic logic [1:0] exp_code(input logic [15:0] w);
        for (int i = 0; i < 3; i++) begin
            if (sync_q[i] === w) return i[1:0];
        end
        return 2'h3;
    endfunction : exp_code

    function automatic bit cond(input int sel);
        case (sel)
            0: return tx_active === 1'b1;
            1: return tx_sample !== 12'h000;
            default: return tx_active === 1'b0;
        endcase
    endfunction : cond

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Bounded wait; running out counts as a failure and ends the run
    task automatic wait_until(input int sel, input int bound);
        int n;
        n = 0;
        while (n < bound && !cond(sel)) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check({15'h0000, cond(sel)}, 16'h0001);
        if (n >= bound) print_verdict();
    endtask : wait_until

    initial begin
        logic [15:0] a;
        logic [15:0] w;
        i_rstn = 1'b0;
        i_rx_bit = 1'b0;
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        #1;
        check({4'h0, tx_sample}, 16'h0000);
        check({13'h0000, tx_active, inband, wrdy | transmit_complete_event}, 16'h0000);
        i_ffskm_host_model.reg_rd(`FFSKM_A_SYNC_C, rd);
        check(rd, `FFSKM_SYNC_RESET);
        $display("test reset done");

        // Unmapped places read as zero and ignore writes
        a = rnd() & 16'h003f;
        i_ffskm_host_model.reg_wr(a[7:0], rnd());
        i_ffskm_host_model.reg_rd(a[7:0], rd);
        check(rd, 16'h0000);
        w = rnd();
        i_ffskm_host_model.reg_wr(`FFSKM_A_SYNC_D, w);
        i_ffskm_host_model.reg_rd(`FFSKM_A_SYNC_D, rd);
        check(rd, w);
        sync_q = {`FFSKM_SYNC_RESET, w, ~`FFSKM_SYNC_RESET};
        $display("test registers done");

        // Receive at 2400 with tx left at 1200: preamble, inverted sync, data
        i_ffskm_host_model.modem_on(16'h0002);
        bits_q = {1'b1, 1'b0};
        for (int i = 15; i >= 0; i--) bits_q.push_back(sync_q[2][i]);
        w = rnd();
        bits_q.push_back(w[0]);
        bits_q.push_back(w[1]);
        foreach (bits_q[i]) begin
            @(posedge i_clk);
            i_rx_bit <= bits_q[i];
            repeat (`FFSKM_BIT_HI - 1) @(posedge i_clk);
        end
        check(16'(inband_cnt), 16'h0001);
        i_ffskm_host_model.reg_rd(`FFSKM_A_IRQ, rd);
        check(rd & 16'h0008, 16'h0008);
        i_ffskm_host_model.reg_rd(`FFSKM_A_IRQ, rd);
        check(rd & 16'h0008, 16'h0000);
        i_ffskm_host_model.reg_rd(`FFSKM_A_AUX, rd);
        check(rd & 16'h0103, {7'h00, 1'b1, 6'h00, exp_code(~`FFSKM_SYNC_RESET)});
        check({14'h0000, exp_code(~`FFSKM_SYNC_RESET)}, 16'h0002);
        // Only two data bits followed the sync, so no word may be presented yet
        i_ffskm_host_model.get_word(rd);
        check(rd, 16'h0000);
        i_ffskm_host_model.modem_off();
        $display("test receive sync done");

        // Transmit at 2400 with full level, data sync selected
        i_ffskm_host_model.reg_wr(`FFSKM_A_AMODE, 16'h0100);
        i_ffskm_host_model.put_word(rnd());
        i_ffskm_host_model.modem_on(16'hf001);
        wait_until(0, 20);
        wait_until(1, `FFSKM_BIT_HI);
        i_ffskm_host_model.end_tx();
        i_ffskm_host_model.modem_off();
        wait_until(2, 20);
        repeat (2) @(posedge i_clk);
        #1;
        check({4'h0, tx_sample}, 16'h0000);
        $display("test transmit start done");
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
